// ==== rtl/interrupt_aggregator.sv ====
/*
  Top-level interrupt aggregator: status, enable and pin configuration
  registers on APB, source aggregation, de-assertion timer and pin stage.
  Assumes source inputs come from logic on pclk and xtal_clk is a free
  running crystal clock that is asynchronous to pclk.
*/
// Decided for this implementation: the APB interface to the registers.
// Notes on behaviour
// - each pin has its own interrupt; any pending one with its sub-enable set sets the pin summary
// - pin events need sub-enable, summary enable and output enable
// - sixteen host MAC events are sticky in status, enabled in enable
// - a MAC event reaches the pin through its enable and output enable
// - any pending power event with its sub-enable set sets the power summary bit
// - power events need sub-enable, power enable and output enable
// - timer count wrapping from zero to all ones sets timer status
// - timer status stays set until software writes one to it
// - timer status reaches the pin only with timer run and enables
// - a zero-to-one write of the software enable sets software status
// - software status reaches the pin with only the output enable
// - the ready status sets once the block is accessible after reset
// - writing one clears ready status, zero leaves it
// - ready status reaches the pin via its enable and output enable
// - clock select puts the crystal clock on the request pin
// - config at 054h, status at 058h, enable at 05Ch
// - output enable clear keeps the pin idle unless clock select is set, status still updates
// - power request joins after the de-assertion gate
// - interval counts in 10 us units; zero disables and releases
// - polarity sets push-pull sense; open-drain is always active low
`timescale 1ns/100ps
`include "irq_agg_regs.svh"
module interrupt_aggregator
  import irq_agg_pkg::*;
(
  // clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output word_t                      prdata,
  output logic                       pready,
  output logic                       pslverr,
  // interrupt sources
  input  wire logic [`PIN_COUNT-1:0] pin_group_status,
  input  wire logic [`PIN_COUNT-1:0] pin_group_enable,
  input  wire logic [15:0]           mac_event,
  input  wire logic [`PWR_COUNT-1:0] power_status,
  input  wire logic [`PWR_COUNT-1:0] power_enable,
  input  wire logic [15:0]           timer_count_value,
  input  wire logic                  timer_run_enable,
  // crystal clock for test output
  input  wire logic                  xtal_clk,
  // request pin
  output logic                       irq_o,
  output logic                       irq_oe
);

  function automatic logic addr_is(input logic [11:0] a,
                                   input logic [11:0] off);
    return a[11:2] == off[11:2];
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // declarations

  word_t      prdata_q;
  logic       pready_q;
  logic       pslverr_q;
  word_t      rd_c;
  logic       setup_c;
  logic       mapped_c;
  logic       wr_cfg_c;
  logic       wr_sts_c;
  logic       wr_en_c;

  interval_t  deas_q;
  logic       irq_en_q;
  logic       pol_q;
  logic       clk_sel_q;
  logic       type_q;

  word_t      en_q;
  word_t      en_d;
  logic [15:0] mac_q;
  logic       pin_sum_q;
  logic       pme_sum_q;
  logic       gpt_q;
  logic       sw_q;
  logic       ready_q;
  logic       ready_seen_q;
  logic [15:0] tmr_prev_q;
  logic       wrap_c;
  logic       sw_rise_c;
  word_t      sts_c;
  word_t      gate_c;
  logic       irq_int_c;
  logic       req_c;
  logic       pme_c;
  logic       pin_active_c;
  logic       pin_asserted_c;

  deas_if dt ();

  //////////////////////////////////////////////////////////////////////////
  // apb slave: no wait states, answer registered in the setup cycle

  assign setup_c  = psel & ~penable;
  assign mapped_c = addr_is(paddr, `OFF_CFG) | addr_is(paddr, `OFF_STS) |
                    addr_is(paddr, `OFF_EN);
  assign wr_cfg_c = psel & penable & pready_q & pwrite &
                    addr_is(paddr, `OFF_CFG);
  assign wr_sts_c = psel & penable & pready_q & pwrite &
                    addr_is(paddr, `OFF_STS);
  assign wr_en_c  = psel & penable & pready_q & pwrite &
                    addr_is(paddr, `OFF_EN);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= setup_c;
      pslverr_q <= setup_c & ~mapped_c;
      if (setup_c) prdata_q <= rd_c;
    end
  end

  always_comb begin
    rd_c = 32'h0000_0000;
    if (addr_is(paddr, `OFF_CFG)) begin
      rd_c[`CFG_DEAS_HI:`CFG_DEAS_LO] = deas_q;
      rd_c[`CFG_DEAS_STS] = dt.in_wait;
      rd_c[`CFG_IRQ_INT]  = irq_int_c;
      rd_c[`CFG_IRQ_EN]   = irq_en_q;
      rd_c[`CFG_POL]      = pol_q;
      rd_c[`CFG_CLK_SEL]  = clk_sel_q;
      rd_c[`CFG_TYPE]     = type_q;
    end else if (addr_is(paddr, `OFF_STS)) begin
      rd_c = sts_c;
    end else if (addr_is(paddr, `OFF_EN)) begin
      rd_c = en_q;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  //////////////////////////////////////////////////////////////////////////
  // configuration register

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      deas_q    <= interval_t'(`CFG_RESET >> `CFG_DEAS_LO);
      irq_en_q  <= 1'b0;
      pol_q     <= 1'b0;
      clk_sel_q <= 1'b0;
      type_q    <= 1'b0;
    end else if (wr_cfg_c) begin
      deas_q    <= pwdata[`CFG_DEAS_HI:`CFG_DEAS_LO];
      irq_en_q  <= pwdata[`CFG_IRQ_EN];
      pol_q     <= pwdata[`CFG_POL];
      clk_sel_q <= pwdata[`CFG_CLK_SEL];
      type_q    <= pwdata[`CFG_TYPE];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // enable register

  always_comb begin
    en_d = en_q;
    if (wr_en_c) en_d = pwdata;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) en_q <= `EN_RESET;
    else en_q <= en_d;
  end

  assign sw_rise_c = en_d[`STS_SW] & ~en_q[`STS_SW];

  //////////////////////////////////////////////////////////////////////////
  // status sources; a set in the clearing cycle wins

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_sum_q <= 1'b0;
      pme_sum_q <= 1'b0;
    end else begin
      pin_sum_q <= |(pin_group_status & pin_group_enable);
      pme_sum_q <= |(power_status & power_enable);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) mac_q <= 16'h0000;
    else mac_q <= (mac_q & ~({16{wr_sts_c}} & pwdata[`STS_MAC_HI:0])) |
                  mac_event;
  end

  assign wrap_c = (tmr_prev_q == `TMR_ZERO) &
                  (timer_count_value == `TMR_WRAP);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr_prev_q <= `TMR_ZERO;
      gpt_q      <= 1'b0;
    end else begin
      tmr_prev_q <= timer_count_value;
      if (wrap_c) gpt_q <= 1'b1;
      else if (wr_sts_c && pwdata[`STS_GPT]) gpt_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sw_q <= 1'b0;
    else if (sw_rise_c) sw_q <= 1'b1;
    else if (wr_sts_c && pwdata[`STS_SW]) sw_q <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_seen_q <= 1'b0;
      ready_q      <= 1'b0;
    end else begin
      ready_seen_q <= 1'b1;
      if (!ready_seen_q) ready_q <= 1'b1;
      else if (wr_sts_c && pwdata[`STS_READY]) ready_q <= 1'b0;
    end
  end

  always_comb begin
    sts_c = 32'h0000_0000;
    sts_c[`STS_MAC_HI:0] = mac_q;
    sts_c[`STS_PIN]   = pin_sum_q;
    sts_c[`STS_PME]   = pme_sum_q;
    sts_c[`STS_GPT]   = gpt_q;
    sts_c[`STS_SW]    = sw_q;
    sts_c[`STS_READY] = ready_q;
  end

  //////////////////////////////////////////////////////////////////////////
  // request gating

  assign irq_int_c = |(sts_c & en_q);

  always_comb begin
    gate_c = en_q;
    gate_c[`STS_GPT] = en_q[`STS_GPT] & timer_run_enable;
    gate_c[`STS_SW]  = 1'b1;
    gate_c[`STS_PME] = 1'b0;
  end

  assign req_c = |(sts_c & gate_c);
  assign pme_c = pme_sum_q & en_q[`STS_PME];

  assign dt.interval = deas_q;
  assign dt.clear    = wr_cfg_c & pwdata[`CFG_DEAS_CLR];
  assign dt.request  = req_c;
  assign dt.enable   = irq_en_q;

  assign pin_active_c = dt.active | (irq_en_q & pme_c);

  deassert_timer u_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .dt      (dt.timer)
  );

  pin_driver u_pin (
    .pclk      (pclk),
    .presetn   (presetn),
    .active    (pin_active_c),
    .clk_sel   (clk_sel_q),
    .polarity  (pol_q),
    .push_pull (type_q),
    .xtal_clk  (xtal_clk),
    .irq_o     (irq_o),
    .irq_oe    (irq_oe)
  );

  //////////////////////////////////////////////////////////////////////////
  // checks

  assign pin_asserted_c = type_q ? (irq_o == pol_q) : irq_oe;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence pme_held;
    (pme_c && irq_en_q && !clk_sel_q && $stable(type_q) &&
     $stable(pol_q)) [*2];
  endsequence

  pin_sum_a: assert property (
    ##1 pin_sum_q == $past(|(pin_group_status & pin_group_enable)))
    else $error("pin summary does not follow pin events");
  pme_sum_a: assert property (
    ##1 pme_sum_q == $past(|(power_status & power_enable)))
    else $error("power summary does not follow power events");
  mac_set_a: assert property (
    (mac_event != 16'h0000) |=> ((mac_q & $past(mac_event)) ==
                                 $past(mac_event)))
    else $error("host MAC event lost");
  gpt_wrap_a: assert property (wrap_c |=> gpt_q)
    else $error("timer wrap did not set status");
  gpt_hold_a: assert property (
    gpt_q && !(wr_sts_c && pwdata[`STS_GPT]) |=> gpt_q)
    else $error("timer status dropped without a clear");
  sw_edge_a: assert property ($rose(en_q[`STS_SW]) |-> sw_q)
    else $error("software enable edge did not set status");
  ready_clr_a: assert property (
    ready_seen_q && wr_sts_c && pwdata[`STS_READY] |=> !ready_q)
    else $error("ready status not cleared by write of one");
  irq_off_a: assert property (
    (!irq_en_q && !clk_sel_q && $stable(type_q) && $stable(pol_q)) [*3]
    |-> !pin_asserted_c)
    else $error("pin asserted with output disabled");
  pme_pass_a: assert property (pme_held |-> pin_asserted_c)
    else $error("power request did not reach the pin");
  unmapped_a: assert property (
    setup_c && !mapped_c |=> pslverr && pready && (prdata == 32'h0))
    else $error("unmapped access not flagged");

endmodule

// ==== rtl/irq_agg_regs.svh ====
/*
  Register offsets, field positions, reset values and timing counts of the
  interrupt aggregator.
  Assumes a 50 MHz pclk and a 12-bit byte address on the register bus.
*/
`ifndef IRQ_AGG_REGS_SVH
`define IRQ_AGG_REGS_SVH

// register byte offsets
`define OFF_CFG        12'h054
`define OFF_STS        12'h058
`define OFF_EN         12'h05C

// configuration register fields
`define CFG_DEAS_HI    31
`define CFG_DEAS_LO    24
`define CFG_DEAS_CLR   14
`define CFG_DEAS_STS   13
`define CFG_IRQ_INT    12
`define CFG_IRQ_EN     8
`define CFG_POL        4
`define CFG_CLK_SEL    1
`define CFG_TYPE       0

// status and enable register fields (same layout in both)
`define STS_MAC_HI     15
`define STS_PIN        16
`define STS_PME        17
`define STS_GPT        19
`define STS_READY      30
`define STS_SW         31

// reset values
`define CFG_RESET      32'h0000_0000
`define EN_RESET       32'h0000_0000

// source widths
`define PIN_COUNT      12
`define PWR_COUNT      8

// timer wrap detection
`define TMR_ZERO       16'h0000
`define TMR_WRAP       16'hFFFF

// de-assertion interval unit
`define CLK_PERIOD_NS  20
`define DEAS_UNIT_US   10
`define DEAS_UNIT_CYC  ((`DEAS_UNIT_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ==== rtl/irq_agg_pkg.sv ====
/*
  Types shared by the interrupt aggregator modules.
  Assumes nothing of its surroundings.
*/
package irq_agg_pkg;
  typedef logic [31:0] word_t;
  typedef logic [7:0]  interval_t;
  typedef enum {DT_OPEN, DT_HOLD} deas_state_e;
endpackage

// ==== rtl/deas_if.sv ====
/*
  Link between the register side and the de-assertion timer.
  Assumes one clock domain on both sides.
*/
`timescale 1ns/100ps
interface deas_if;
  import irq_agg_pkg::*;
  interval_t interval;
  logic      clear;
  logic      request;
  logic      enable;
  logic      active;
  logic      in_wait;
  modport ctrl  (output interval, clear, request, enable,
                 input  active, in_wait);
  modport timer (input  interval, clear, request, enable,
                 output active, in_wait);
endinterface

// ==== rtl/deassert_timer.sv ====
/*
  De-assertion timer: gates the request and enforces a minimum idle time
  on the request line after every fall.
  Assumes interval and clear come from logic on pclk.
*/
`timescale 1ns/100ps
`include "irq_agg_regs.svh"
module deassert_timer
  import irq_agg_pkg::*;
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // control side
  deas_if.timer     dt
);

  localparam logic [8:0] UNIT_LAST = 9'(`DEAS_UNIT_CYC - 1);

  deas_state_e state_q;
  logic        active_q;
  logic [8:0]  pre_q;
  interval_t   units_q;
  logic        want_c;
  logic        reload_c;
  logic        expire_c;
  logic        zero_c;

  assign want_c   = dt.enable & dt.request;
  assign zero_c   = (dt.interval == 8'h00);
  // a fall of the line or an explicit clear starts a new interval
  assign reload_c = ~zero_c & (dt.clear |
                    ((state_q == DT_OPEN) & active_q & ~want_c));
  assign expire_c = (pre_q == 9'h000) & (units_q == 8'h01);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= DT_OPEN;
    end else begin
      unique case (state_q)
        DT_OPEN: begin
          if (reload_c) state_q <= DT_HOLD;
        end
        DT_HOLD: begin
          if (zero_c || (expire_c && !dt.clear)) state_q <= DT_OPEN;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q   <= 9'h000;
      units_q <= 8'h00;
    end else if (zero_c) begin
      pre_q   <= 9'h000;
      units_q <= 8'h00;
    end else if (reload_c) begin
      pre_q   <= UNIT_LAST;
      units_q <= dt.interval;
    end else if (state_q == DT_HOLD) begin
      if (pre_q == 9'h000) begin
        pre_q   <= UNIT_LAST;
        units_q <= units_q - 8'h01;
      end else begin
        pre_q   <= pre_q - 9'h001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) active_q <= 1'b0;
    else active_q <= (state_q == DT_OPEN) & ~reload_c & want_c;
  end

  assign dt.active  = active_q;
  assign dt.in_wait = (state_q == DT_HOLD);

  deas_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    zero_c |=> (state_q == DT_OPEN) && (units_q == 8'h00))
    else $error("zero interval did not release the timer");

endmodule

// ==== rtl/pin_driver.sv ====
/*
  Request pin output stage: polarity, buffer type and clock test mode.
  Assumes xtal_clk is asynchronous to pclk and slow enough to be sampled.
*/
`timescale 1ns/100ps
module pin_driver (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // control
  input  wire logic active,
  input  wire logic clk_sel,
  input  wire logic polarity,
  input  wire logic push_pull,
  input  wire logic xtal_clk,
  // pin
  output logic      irq_o,
  output logic      irq_oe
);

  logic xtal_meta_q;
  logic xtal_sync_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xtal_meta_q <= 1'b0;
      xtal_sync_q <= 1'b0;
    end else begin
      xtal_meta_q <= xtal_clk;
      xtal_sync_q <= xtal_meta_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_o  <= 1'b0;
      irq_oe <= 1'b0;
    end else if (push_pull) begin
      irq_oe <= 1'b1;
      irq_o  <= clk_sel ? xtal_sync_q : (polarity ? active : ~active);
    end else begin
      irq_o  <= 1'b0;
      irq_oe <= clk_sel ? ~xtal_sync_q : active;
    end
  end

endmodule

// ==== tb/irq_host_model.sv ====
/*
  Host interrupt input: resolves the request line and decides whether
  the host sees a request.
  Assumes a pull-up on the line and that the host knows the pin setup.
*/
`timescale 1ns/100ps
module irq_host_model (
  // pin
  input  wire logic irq_o,
  input  wire logic irq_oe,
  // host view of the pin setup
  input  wire logic polarity,
  input  wire logic push_pull,
  // result
  output logic      pin_level,
  output logic      asserted
);
  // a released line floats up through the pull-up
  assign pin_level = irq_oe ? irq_o : 1'b1;
  // open-drain is always active low
  assign asserted  = (push_pull && polarity) ? pin_level : !pin_level;
endmodule

// ==== tb/interrupt_aggregator_tb.sv ====
/*
  Self-checking bench of the interrupt aggregator: APB master tasks,
  source stimulus and a host model on the request pin.
  Assumes the register header and package of the design.
*/
`timescale 1ns/100ps
`include "irq_agg_regs.svh"
module interrupt_aggregator_tb
  import irq_agg_pkg::*;
;
  localparam word_t PP_HI = 32'h0000_0111;
  logic                  pclk, presetn, psel, penable, pwrite;
  logic [11:0]           paddr;
  word_t                 pwdata, prdata, rdata;
  logic                  pready, pslverr, rerr;
  logic [`PIN_COUNT-1:0] pin_group_status, pin_group_enable;
  logic [15:0]           mac_event, timer_count_value;
  logic [`PWR_COUNT-1:0] power_status, power_enable;
  logic                  timer_run_enable, xtal_clk, irq_o, irq_oe;
  logic                  host_pol, host_pp, pin_level, asserted;
  int                    n_errors, checks;

  always #10 pclk = ~pclk;
  always #37 xtal_clk = ~xtal_clk;

  interrupt_aggregator i_interrupt_aggregator (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .pin_group_status, .pin_group_enable, .mac_event,
    .power_status, .power_enable, .timer_count_value, .timer_run_enable,
    .xtal_clk, .irq_o, .irq_oe);
  irq_host_model i_irq_host_model (
    .irq_o, .irq_oe, .polarity(host_pol), .push_pull(host_pp), .pin_level,
    .asserted);

  //////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    if (n_errors == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input word_t seen, input word_t exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input word_t d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_errors++;
      end_of_test();
    end
    rdata = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input word_t d);
    apb(1'b1, a, d);
  endtask

  task automatic rd_bit(input string nm, input logic [11:0] a, input int b,
                        input logic e);
    apb(1'b0, a, '0);
    chk(nm, 32'(rdata[b]), 32'(e));
    chk("mapped no err", 32'(rerr), 32'h0000_0000);
  endtask

  // pin lag is a few cycles; eight leaves margin
  task automatic pin(input string nm, input logic e);
    repeat (8) @(posedge pclk);
    chk(nm, 32'(asserted), 32'(e));
  endtask

  task automatic set_cfg(input word_t v);
    wr(`OFF_CFG, v);
    host_pol <= v[`CFG_POL];
    host_pp  <= v[`CFG_TYPE];
  endtask

  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset_regs;
    apb(1'b0, `OFF_CFG, '0);
    chk("cfg reset", rdata, `CFG_RESET);
    apb(1'b0, `OFF_EN, '0);
    chk("en reset", rdata, `EN_RESET);
    apb(1'b0, `OFF_STS, '0);
    chk("sts reset", rdata, 32'h4000_0000);
    apb(1'b0, 12'h060, '0);
    chk("unmapped err", 32'(rerr), 32'h0000_0001);
    chk("unmapped data", rdata, 32'h0000_0000);
  endtask

  task automatic t_ready;
    set_cfg(PP_HI);
    wr(`OFF_EN, 32'h4000_0000);
    pin("ready pin", 1'b1);
    rd_bit("master req", `OFF_CFG, `CFG_IRQ_INT, 1'b1);
    set_cfg(32'h0000_0101);
    pin("active low", 1'b1);
    chk("low level", 32'(irq_o), 32'h0000_0000);
    set_cfg(32'h0000_0110);
    pin("open drain", 1'b1);
    chk("od drive", {30'h0, irq_oe, irq_o}, 32'h0000_0002);
    set_cfg(32'h0000_0011);
    pin("oe off", 1'b0);
    rd_bit("ready kept", `OFF_STS, `STS_READY, 1'b1);
    wr(`OFF_STS, 32'h0000_0000);
    rd_bit("ready w0", `OFF_STS, `STS_READY, 1'b1);
    wr(`OFF_STS, 32'h4000_0000);
    rd_bit("ready w1", `OFF_STS, `STS_READY, 1'b0);
    set_cfg(PP_HI);
    pin("ready gone", 1'b0);
    wr(`OFF_EN, 32'h0000_0000);
  endtask

  task automatic t_mac;
    for (int i = 0; i < 16; i++) begin
      @(posedge pclk);
      mac_event <= 16'h0001 << i;
      @(posedge pclk);
      mac_event <= 16'h0000;
      apb(1'b0, `OFF_STS, '0);
      chk("mac sticky", {16'h0, rdata[15:0]}, 32'h0000_0001 << i);
      wr(`OFF_STS, 32'h0000_0001 << i);
    end
    @(posedge pclk);
    mac_event <= 16'h0008;
    @(posedge pclk);
    mac_event <= 16'h0000;
    pin("mac no en", 1'b0);
    wr(`OFF_EN, 32'h0000_0008);
    pin("mac pin", 1'b1);
  endtask

  task automatic t_deas;
    set_cfg(32'h0100_0111);
    wr(`OFF_EN, 32'h0000_0000);
    rd_bit("in interval", `OFF_CFG, `CFG_DEAS_STS, 1'b1);
    repeat (`DEAS_UNIT_CYC - 30) @(posedge pclk);
    rd_bit("interval runs", `OFF_CFG, `CFG_DEAS_STS, 1'b1);
    repeat (40) @(posedge pclk);
    rd_bit("interval ends", `OFF_CFG, `CFG_DEAS_STS, 1'b0);
    set_cfg(32'h0100_4111);
    rd_bit("clear starts", `OFF_CFG, `CFG_DEAS_STS, 1'b1);
    rd_bit("clear self", `OFF_CFG, `CFG_DEAS_CLR, 1'b0);
    repeat (`DEAS_UNIT_CYC) @(posedge pclk);
    wr(`OFF_EN, 32'h0000_0008);
    pin("mac again", 1'b1);
    wr(`OFF_EN, 32'h0000_0000);
    @(posedge pclk);
    power_status <= 8'h01;
    power_enable <= 8'h01;
    rd_bit("pwr summary", `OFF_STS, `STS_PME, 1'b1);
    pin("pwr no en", 1'b0);
    wr(`OFF_EN, 32'h0002_0000);
    pin("pwr bypass", 1'b1);
    set_cfg(PP_HI);
    rd_bit("zero interval", `OFF_CFG, `CFG_DEAS_STS, 1'b0);
    power_enable <= 8'h00;
    rd_bit("pwr masked", `OFF_STS, `STS_PME, 1'b0);
    pin("pwr gone", 1'b0);
    power_status <= 8'h00;
    wr(`OFF_EN, 32'h0000_0000);
    wr(`OFF_STS, 32'h0000_0008);
  endtask

  task automatic t_pins;
    @(posedge pclk);
    pin_group_status <= 12'h020;
    rd_bit("pin sum off", `OFF_STS, `STS_PIN, 1'b0);
    pin_group_enable <= 12'h020;
    rd_bit("pin sum on", `OFF_STS, `STS_PIN, 1'b1);
    pin("pin no en", 1'b0);
    wr(`OFF_EN, 32'h0001_0000);
    pin("pin group", 1'b1);
    set_cfg(32'h0000_0011);
    pin("pin oe off", 1'b0);
    set_cfg(PP_HI);
    pin_group_enable <= 12'h000;
    pin("pin masked", 1'b0);
    pin_group_status <= 12'h000;
    wr(`OFF_EN, 32'h0000_0000);
  endtask

  task automatic t_timer;
    @(posedge pclk);
    timer_count_value <= 16'h0001;
    @(posedge pclk);
    timer_count_value <= 16'h0000;
    rd_bit("no wrap", `OFF_STS, `STS_GPT, 1'b0);
    timer_count_value <= 16'hFFFF;
    @(posedge pclk);
    timer_count_value <= 16'hFFFE;
    rd_bit("wrap", `OFF_STS, `STS_GPT, 1'b1);
    wr(`OFF_EN, 32'h0008_0000);
    pin("tmr stopped", 1'b0);
    timer_run_enable <= 1'b1;
    pin("tmr run", 1'b1);
    rd_bit("tmr held", `OFF_STS, `STS_GPT, 1'b1);
    wr(`OFF_STS, 32'h0008_0000);
    rd_bit("tmr clr", `OFF_STS, `STS_GPT, 1'b0);
    pin("tmr gone", 1'b0);
    wr(`OFF_EN, 32'h0000_0000);
    timer_run_enable <= 1'b0;
  endtask

  task automatic t_soft;
    wr(`OFF_EN, 32'h8000_0000);
    rd_bit("sw set", `OFF_STS, `STS_SW, 1'b1);
    wr(`OFF_EN, 32'h0000_0000);
    rd_bit("sw kept", `OFF_STS, `STS_SW, 1'b1);
    pin("sw pin", 1'b1);
    wr(`OFF_STS, 32'h8000_0000);
    rd_bit("sw clr", `OFF_STS, `STS_SW, 1'b0);
    pin("sw gone", 1'b0);
  endtask

  task automatic t_clock;
    int   t;
    logic last;
    set_cfg(32'h0000_0113);
    for (int m = 0; m < 2; m++) begin
      repeat (8) @(posedge pclk);
      t = 0;
      last = irq_o;
      repeat (40) begin
        @(posedge pclk);
        if (irq_o !== last) t++;
        last = irq_o;
      end
      chk("clock out", 32'(t > 10), 32'(m == 0));
      if (m == 0) set_cfg(PP_HI);
    end
  endtask

  // reset in mid-run brings the ready status back and clears the setup
  task automatic t_rerst;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `OFF_STS, '0);
    chk("ready again", rdata, 32'h4000_0000);
    apb(1'b0, `OFF_CFG, '0);
    chk("cfg again", rdata, `CFG_RESET);
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    xtal_clk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {pin_group_status, pin_group_enable, mac_event} = '0;
    {power_status, power_enable, timer_count_value} = '0;
    timer_run_enable = 1'b0;
    {host_pol, host_pp} = 2'b00;
    n_errors = 0;
    checks = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_regs();
    t_ready();
    t_mac();
    t_deas();
    t_pins();
    t_timer();
    t_soft();
    t_clock();
    t_rerst();
    end_of_test();
  end

  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    end_of_test();
  end
endmodule
